/* verilog/nand_host_ctrl.sv */
// Host-side controller that sequences NAND flash operations over the byte port.
// How it works
// (R1) First address byte carries column bits 0 to 7, the page start byte.
// (R2) Second address byte carries address bits 9 to 16, the low row.
// (R3) Third address byte carries address bits 17 to 21 on lines 0 to 4.
// (R4) Unused upper lines of the third address byte are driven low here.
// (R5) Half select bit is never sent as address; it picks the read command.
// (R6) Read with half select low issues command 00h, first half.
// (R7) Read with half select high issues command 01h, second half.
// (R8) Program sends one page of up to 528 bytes, then waits busy.
// (R9) Erase sends only two row bytes and clears a whole 8K block.
// (R10) Page read waits ready, at most 10 us, before reading bytes.
// (R11) Read bytes one per strobe, strobe cycle never below 50 ns.
// (R12) Program and erase need only the command pair; device runs them alone.
// (R13) Bad blocks are marked 00h at byte 517 of their first page.
// (R14) Block is bad when byte 517 holds two or more zero bits.
// (R15) Write protect is held low while supply power is not good.
// (R16) Command or address latch high selects byte type at rising write edge.
// (R17) Each read strobe fall advances the device column counter by one.
// (R18) After second-half access the device pointer returns to first half.
// (R19) Ready busy pin is low during array work, high when done.
// (R20) A new operation starts only when ready busy is high.
`timescale 1ns/1ns
module nand_host_ctrl
	import nand_host_pkg::*;
#(
	parameter int BUSY_LIMIT_CYC = ERASE_TYP_CYC * BUSY_MARGIN
)(
	// Clock and reset.
	input  wire logic              core_clk_in,
	input  wire logic              sys_rst_in,
	// User request.
	input  wire logic              start_in,
	input  wire op_t               op_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [LEN_W-1:0]  len_in,
	input  wire logic              power_good_in,
	// User write stream.
	input  wire logic              wr_valid_in,
	input  wire logic [7:0]        wr_data_in,
	output logic                   wr_ready_out,
	// User read stream and status.
	output logic                   rd_valid_out,
	output logic [7:0]             rd_data_out,
	output logic                   busy_out,
	output logic                   done_out,
	output logic                   timeout_out,
	output logic                   bad_block_out,
	// Flash pins.
	input  wire logic [7:0]        port_in,
	output logic [7:0]             port_out,
	output logic                   port_oe_out,
	output logic                   cle_out,
	output logic                   ale_out,
	output logic                   ce_n_out,
	output logic                   we_n_out,
	output logic                   read_strobe_n_out,
	output logic                   wp_n_out,
	input  wire logic              ready_busy_n_in
);

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_CMD1   = 4'b0001,
		S_ADDR   = 4'b0010,
		S_WDATA  = 4'b0011,
		S_CMD2   = 4'b0100,
		S_SETTLE = 4'b0101,
		S_WAIT   = 4'b0110,
		S_RDATA  = 4'b0111,
		S_DONE   = 4'b1000
	} ctrl_state_t;

	// ==========================================================================
	// Helpers.
	// Address byte by cycle index; upper lines of the last cycle go out as zero.
	function automatic logic [7:0] addr_byte(input logic [ADDR_W-1:0] a, input logic [1:0] idx);
		unique case (idx)
			2'd0:    addr_byte = a[COL_LSB +: 8];                    // R1
			2'd1:    addr_byte = a[ROW_LO_LSB +: 8];                 // R2
			default: addr_byte = {3'h0, a[ROW_HI_LSB +: ROW_HI_W]}; // R3 R4
		endcase
	endfunction : addr_byte

	function automatic logic [3:0] zero_count(input logic [7:0] b);
		zero_count = 4'h0;
		for (int i = 0; i < 8; i++) begin
			zero_count = zero_count + {3'h0, ~b[i]};
		end
	endfunction : zero_count

	localparam logic [ADDR_W-1:0] MARK_ADDR_COL = ADDR_W'(MARK_COLUMN - SPARE_BASE);
	localparam logic [CNT_W-1:0]  READ_LIMIT    = CNT_W'(READ_MAX_CYC);
	localparam logic [CNT_W-1:0]  BUSY_LIMIT    = CNT_W'(BUSY_LIMIT_CYC);
	localparam logic [CNT_W-1:0]  SETTLE_LIMIT  = CNT_W'(BUSY_SETTLE_CYC);

	ctrl_state_t       state_reg;
	op_t               op_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [LEN_W-1:0]  left_reg;
	logic [1:0]        idx_reg;
	logic              wait_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic              eng_done;
	logic [7:0]        eng_byte;
	logic              issue;
	kind_t             issue_kind;
	logic [7:0]        issue_byte;
	logic [7:0]        first_cmd;
	logic [7:0]        second_cmd;
	logic              last_addr;
	logic              take_wr;

	// ==========================================================================
	// Command selection per operation.
	always_comb begin
		unique case (op_reg)
			OP_READ:    first_cmd = addr_reg[HALF_SEL_BIT] ? CMD_READ_SECOND : CMD_READ_FIRST; // R5 R6 R7
			OP_PROGRAM: first_cmd = CMD_PROG_SETUP;
			OP_ERASE:   first_cmd = CMD_ERASE_SETUP;
			OP_STATUS:  first_cmd = CMD_STATUS;
			OP_RESET:   first_cmd = CMD_RESET;
			default:    first_cmd = CMD_READ_SPARE; // R13
		endcase
		second_cmd = (op_reg == OP_ERASE) ? CMD_ERASE_GO : CMD_PROG_GO; // R12
		last_addr  = (idx_reg == 2'd2);
	end

	// What to hand the cycle engine in the present state.
	always_comb begin
		take_wr    = (state_reg == S_WDATA) && wr_ready_out && wr_valid_in;
		issue      = 1'b0;
		issue_kind = KIND_CMD;
		issue_byte = 8'h00;
		unique case (state_reg)
			S_CMD1: begin
				issue      = !wait_reg;
				issue_byte = first_cmd;
			end
			S_ADDR: begin
				issue      = !wait_reg;
				issue_kind = KIND_ADDR;
				issue_byte = addr_byte(addr_reg, idx_reg);
			end
			S_WDATA: begin
				issue      = take_wr;
				issue_kind = KIND_WDATA;
				issue_byte = wr_data_in;
			end
			S_CMD2: begin
				issue      = !wait_reg;
				issue_byte = second_cmd;
			end
			S_RDATA: begin
				issue      = !wait_reg;
				issue_kind = KIND_RDATA;
			end
			default: issue = 1'b0;
		endcase
	end

	// ==========================================================================
	// Operation sequencer.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= S_IDLE;
			op_reg    <= OP_STATUS;
			addr_reg  <= '0;
			left_reg  <= '0;
			idx_reg   <= 2'd0;
			wait_reg  <= 1'b0;
			cnt_reg   <= '0;
		end else begin
			if (issue) begin
				wait_reg <= 1'b1;
			end else if (eng_done) begin
				wait_reg <= 1'b0;
			end
			unique case (state_reg)
				S_IDLE: begin
					// Ready must be high before a new operation is accepted.
					if (start_in && ready_busy_n_in && op_in <= OP_BADCHK) begin // R20
						state_reg <= S_CMD1;
						op_reg    <= op_in;
						addr_reg  <= (op_in == OP_BADCHK) ? {addr_in[ADDR_W-1:ROW_LO_LSB],
							MARK_ADDR_COL[ROW_LO_LSB-1:0]} : addr_in;
						left_reg  <= (op_in == OP_BADCHK || op_in == OP_STATUS) ?
							LEN_W'(1) : len_in;
						idx_reg   <= (op_in == OP_ERASE) ? 2'd1 : 2'd0; // R9
					end
				end
				S_CMD1: begin
					if (eng_done) begin
						unique case (op_reg)
							OP_STATUS: state_reg <= S_RDATA;
							OP_RESET:  state_reg <= S_SETTLE;
							default:   state_reg <= S_ADDR;
						endcase
					end
				end
				S_ADDR: begin
					if (eng_done) begin
						idx_reg <= idx_reg + 2'd1;
						if (last_addr) begin
							if (op_reg == OP_PROGRAM) begin
								state_reg <= (left_reg == '0) ? S_CMD2 : S_WDATA; // R8
							end else begin
								state_reg <= (op_reg == OP_ERASE) ? S_CMD2 : S_SETTLE;
							end
						end
					end
				end
				S_WDATA: begin
					if (eng_done) begin
						left_reg <= left_reg - LEN_W'(1);
						if (left_reg == LEN_W'(1)) begin
							state_reg <= S_CMD2; // R8
						end
					end
				end
				S_CMD2: begin
					if (eng_done) begin
						state_reg <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					// Give the busy pin time to fall before it is watched.
					cnt_reg <= cnt_reg + CNT_W'(1);
					if (cnt_reg + CNT_W'(1) >= SETTLE_LIMIT) begin
						state_reg <= S_WAIT;
						cnt_reg   <= '0;
					end
				end
				S_WAIT: begin
					cnt_reg <= cnt_reg + CNT_W'(1);
					if (ready_busy_n_in) begin // R19
						state_reg <= (op_reg == OP_READ || op_reg == OP_BADCHK) ? S_RDATA : S_DONE;
						cnt_reg   <= '0;
					end else if (cnt_reg >= ((op_reg == OP_READ || op_reg == OP_BADCHK) ?
						READ_LIMIT : BUSY_LIMIT)) begin // R10
						state_reg <= S_DONE;
						cnt_reg   <= '0;
					end
				end
				S_RDATA: begin
					if (eng_done) begin
						left_reg <= left_reg - LEN_W'(1);
						if (left_reg <= LEN_W'(1)) begin
							state_reg <= S_DONE; // R17
						end
					end
				end
				S_DONE: state_reg <= S_IDLE;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// ==========================================================================
	// User-facing outputs and pin controls that sit outside the engine.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wr_ready_out  <= 1'b0;
			rd_valid_out  <= 1'b0;
			rd_data_out   <= 8'h00;
			busy_out      <= 1'b0;
			done_out      <= 1'b0;
			timeout_out   <= 1'b0;
			bad_block_out <= 1'b0;
			ce_n_out      <= 1'b1;
			wp_n_out      <= 1'b0;
		end else begin
			wr_ready_out <= (state_reg == S_WDATA) && !wait_reg && !take_wr && !eng_done;
			rd_valid_out <= (state_reg == S_RDATA) && eng_done;
			if ((state_reg == S_RDATA) && eng_done) begin
				rd_data_out <= eng_byte;
			end
			if ((state_reg == S_RDATA) && eng_done && op_reg == OP_BADCHK) begin
				bad_block_out <= (zero_count(eng_byte) >= 4'(MARK_ZERO_MIN)); // R14
			end
			if (state_reg == S_IDLE && start_in && ready_busy_n_in) begin
				timeout_out <= 1'b0;
			end else if (state_reg == S_WAIT && !ready_busy_n_in && cnt_reg >=
				((op_reg == OP_READ || op_reg == OP_BADCHK) ? READ_LIMIT : BUSY_LIMIT)) begin
				timeout_out <= 1'b1;
			end
			busy_out <= (state_reg != S_IDLE) && (state_reg != S_DONE);
			done_out <= (state_reg == S_DONE);
			ce_n_out <= (state_reg == S_IDLE) || (state_reg == S_DONE);
			// Releasing protection only on good power keeps stray strobes harmless.
			wp_n_out <= power_good_in; // R15
		end
	end

	byte_cycle_engine u_engine (
		.core_clk_in       (core_clk_in),
		.sys_rst_in        (sys_rst_in),
		.start_in          (issue),
		.kind_in           (issue_kind),
		.byte_in           (issue_byte),
		.done_out          (eng_done),
		.rd_byte_out       (eng_byte),
		.port_in           (port_in),
		.port_out          (port_out),
		.port_oe_out       (port_oe_out),
		.cle_out           (cle_out),
		.ale_out           (ale_out),
		.we_n_out          (we_n_out),
		.read_strobe_n_out (read_strobe_n_out)
	);

	// ==========================================================================
	// Checks.
	property p_col_byte;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(issue && state_reg == S_ADDR && idx_reg == 2'd0) |=> ##1 ale_out && port_out == addr_reg[7:0];
	endproperty
	a_col_byte: assert property (p_col_byte) // R1
		else $error("First address byte is not the column.");

	property p_row_lo_byte;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(issue && state_reg == S_ADDR && idx_reg == 2'd1) |=> port_out == addr_reg[16:9];
	endproperty
	a_row_lo_byte: assert property (p_row_lo_byte) // R2
		else $error("Second address byte is not address bits 9 to 16.");

	property p_row_hi_byte;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(issue && state_reg == S_ADDR && idx_reg == 2'd2) |=> port_out[4:0] == addr_reg[21:17];
	endproperty
	a_row_hi_byte: assert property (p_row_hi_byte) // R3
		else $error("Third address byte is not address bits 17 to 21.");

	property p_row_hi_pad;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(issue && state_reg == S_ADDR && idx_reg == 2'd2) |=> port_out[7:5] == 3'h0;
	endproperty
	a_row_hi_pad: assert property (p_row_hi_pad) // R4
		else $error("Upper lines of the last address byte not at a fixed level.");

	property p_start_when_ready;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(state_reg == S_IDLE && start_in && !ready_busy_n_in) |=> state_reg == S_IDLE;
	endproperty
	a_start_when_ready: assert property (p_start_when_ready) // R20
		else $error("Operation started while the device was busy.");

	property p_bad_mark;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(state_reg == S_RDATA && eng_done && op_reg == OP_BADCHK) |=>
			bad_block_out == ($countones(~$past(eng_byte)) >= MARK_ZERO_MIN);
	endproperty
	a_bad_mark: assert property (p_bad_mark) // R14
		else $error("Bad block verdict does not match the marker byte.");

	c_read: cover property (@(posedge core_clk_in) rd_valid_out && op_reg == OP_READ);
	c_program: cover property (@(posedge core_clk_in) done_out && op_reg == OP_PROGRAM);
	c_erase: cover property (@(posedge core_clk_in) done_out && op_reg == OP_ERASE);
	c_bad: cover property (@(posedge core_clk_in) $rose(bad_block_out));

endmodule : nand_host_ctrl

/* common/nand_host_pkg.sv */
// Constants, command codes and types shared by the NAND host controller files.
package nand_host_pkg;

	// ==========================================================================
	// Clock and timing.
	localparam int CLK_PERIOD_NS    = 100;
	localparam int SERIAL_CYCLE_NS  = 50;
	localparam int PAGE_READ_MAX_US = 10;
	localparam int PROG_TYP_US      = 250;
	localparam int ERASE_TYP_MS     = 2;
	localparam int BUSY_SETTLE_NS   = 200;
	// Least times round up, longest times round down, none below one cycle.
	localparam int SERIAL_MIN_CYC   = (SERIAL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_MAX_CYC     = (PAGE_READ_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int PROG_TYP_CYC     = (PROG_TYP_US * 1000) / CLK_PERIOD_NS;
	localparam int ERASE_TYP_CYC    = (ERASE_TYP_MS * 1000000) / CLK_PERIOD_NS;
	localparam int BUSY_SETTLE_CYC  = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_MARGIN      = 4;

	// ==========================================================================
	// Geometry and address layout.
	localparam int ADDR_W         = 22;
	localparam int LEN_W          = 10;
	localparam int PAGE_BYTES     = 528;
	localparam int COL_LSB        = 0;
	localparam int ROW_LO_LSB     = 9;
	localparam int ROW_HI_LSB     = 17;
	localparam int ROW_HI_W       = 5;
	localparam int HALF_SEL_BIT   = 8;
	localparam int MARK_COLUMN    = 517;
	localparam int SPARE_BASE     = 512;
	localparam int MARK_ZERO_MIN  = 2;
	localparam int CNT_W          = 20;

	// ==========================================================================
	// Command codes.
	localparam logic [7:0] CMD_READ_FIRST  = 8'h00;
	localparam logic [7:0] CMD_READ_SECOND = 8'h01;
	localparam logic [7:0] CMD_READ_SPARE  = 8'h50;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_RESET       = 8'hff;
	localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
	localparam logic [7:0] CMD_PROG_GO     = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO    = 8'hd0;

	// ==========================================================================
	// User operations and bus cycle kinds.
	typedef enum logic [2:0] {
		OP_READ    = 3'b000,
		OP_PROGRAM = 3'b001,
		OP_ERASE   = 3'b010,
		OP_STATUS  = 3'b011,
		OP_RESET   = 3'b100,
		OP_BADCHK  = 3'b101
	} op_t;

	typedef enum logic [1:0] {
		KIND_CMD   = 2'b00,
		KIND_ADDR  = 2'b01,
		KIND_WDATA = 2'b10,
		KIND_RDATA = 2'b11
	} kind_t;

endpackage : nand_host_pkg

/* verilog/byte_cycle_engine.sv */
// One strobed bus cycle on the multiplexed byte port: command, address, write or read.
`timescale 1ns/1ns
module byte_cycle_engine
	import nand_host_pkg::*;
(
	// Clock and reset.
	input  wire logic       core_clk_in,
	input  wire logic       sys_rst_in,
	// Request from the sequencer.
	input  wire logic       start_in,
	input  wire kind_t      kind_in,
	input  wire logic [7:0] byte_in,
	output logic            done_out,
	output logic [7:0]      rd_byte_out,
	// Flash pins.
	input  wire logic [7:0] port_in,
	output logic [7:0]      port_out,
	output logic            port_oe_out,
	output logic            cle_out,
	output logic            ale_out,
	output logic            we_n_out,
	output logic            read_strobe_n_out
);

	typedef enum logic [1:0] {
		E_IDLE = 2'b00,
		E_LOW  = 2'b01,
		E_HIGH = 2'b10
	} eng_state_t;

	eng_state_t state_reg;
	kind_t      kind_reg;

	// ==========================================================================
	// Strobe sequence: strobe low one cycle, high one cycle, then done.
	// Each phase is one 100 ns clock, well above the 50 ns serial minimum.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_reg         <= E_IDLE;
			kind_reg          <= KIND_CMD;
			done_out          <= 1'b0;
			port_out          <= 8'h00;
			port_oe_out       <= 1'b0;
			cle_out           <= 1'b0;
			ale_out           <= 1'b0;
			we_n_out          <= 1'b1;
			read_strobe_n_out <= 1'b1;
		end else begin
			done_out <= 1'b0;
			unique case (state_reg)
				E_IDLE: begin
					if (start_in) begin
						state_reg         <= E_LOW;
						kind_reg          <= kind_in;
						port_out          <= byte_in;
						port_oe_out       <= (kind_in != KIND_RDATA);
						cle_out           <= (kind_in == KIND_CMD);  // R16
						ale_out           <= (kind_in == KIND_ADDR); // R16
						we_n_out          <= (kind_in == KIND_RDATA);
						read_strobe_n_out <= (kind_in != KIND_RDATA);
					end
				end
				E_LOW: begin
					// The device latches on this rising write edge; data stays driven.
					state_reg         <= E_HIGH;
					we_n_out          <= 1'b1; // R16
					read_strobe_n_out <= 1'b1; // R11
				end
				E_HIGH: begin
					state_reg   <= E_IDLE;
					done_out    <= 1'b1;
					port_oe_out <= 1'b0;
					cle_out     <= 1'b0;
					ale_out     <= 1'b0;
				end
				default: state_reg <= E_IDLE;
			endcase
		end
	end

	// Read data is sampled at the end of the low phase, a full clock after the fall.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rd_byte_out <= 8'h00;
		end else if (state_reg == E_LOW && kind_reg == KIND_RDATA) begin
			rd_byte_out <= port_in; // R11
		end
	end

	// ==========================================================================
	// Checks.
	property p_latch_exclusive;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		!(cle_out && ale_out);
	endproperty
	a_latch_exclusive: assert property (p_latch_exclusive) // R16
		else $error("Command and address latch enables high together.");

	property p_read_strobe_pulse;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$fell(read_strobe_n_out) |=> read_strobe_n_out ##1 read_strobe_n_out;
	endproperty
	a_read_strobe_pulse: assert property (p_read_strobe_pulse) // R11
		else $error("Read strobe low phase or cycle spacing wrong.");

	property p_write_edge_driven;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$rose(we_n_out) |-> port_oe_out && $stable(port_out) && $past(we_n_out, 2);
	endproperty
	a_write_edge_driven: assert property (p_write_edge_driven) // R16
		else $error("Byte not held on the port at the rising write edge.");

endmodule : byte_cycle_engine

/* dv/nand_card_model.sv */
// Behavioural card model that answers the host controller on the byte port.
`timescale 1ns/1ns
module nand_card_model #(
	parameter int READ_NS  = 2000,
	parameter int PROG_NS  = 5000,
	parameter int ERASE_NS = 10000
)(
	// Card pins.
	input  wire logic       ce_n_in,
	input  wire logic       cle_in,
	input  wire logic       ale_in,
	input  wire logic       we_n_in,
	input  wire logic       read_strobe_n_in,
	input  wire logic       wp_n_in,
	input  wire logic [7:0] bus_in,
	output logic [7:0]      bus_out,
	output logic            ready_busy_n_out
);
	// ==========================================================================
	// Sparse array; bytes never written read as erased.
	logic [7:0] mem [int];
	logic [7:0] pbuf [int];
	logic [7:0] cmd;
	logic [7:0] a [3];
	logic       half;
	int         acnt;
	int         col;
	int         row;
	int         stretch_ns = 0; // Extra busy time a scenario may add to model a stuck card.

	// The caller stalls while busy, which is safe because the host must wait too.
	task automatic hold_busy(input int ns);
		ready_busy_n_out = 1'b0;
		#(ns + stretch_ns);
		ready_busy_n_out = 1'b1;
	endtask : hold_busy

	// Shipped marks: block 3 holds 00h, block 5 two zero bits, block 6 one zero bit.
	initial begin
		bus_out = 8'h00;
		ready_busy_n_out = 1'b1;
		half = 1'b0;
		acnt = 0;
		mem[48 * 528 + 517] = 8'h00;
		mem[80 * 528 + 517] = 8'hfc;
		mem[96 * 528 + 517] = 8'hfe;
	end

	// Commands, addresses and data latch on the rising write edge.
	always @(posedge we_n_in) begin
		if (!ce_n_in && cle_in) begin
			cmd = bus_in;
			acnt = 0;
			if (bus_in == 8'h00 || bus_in == 8'h01)
				half = bus_in[0];
			if (bus_in == 8'h80)
				pbuf.delete();
			if (bus_in == 8'h10 && wp_n_in) begin
				foreach (pbuf[i])
					mem[row * 528 + i] = pbuf[i];
				hold_busy(PROG_NS);
			end
			if (bus_in == 8'hd0 && wp_n_in) begin
				for (int i = 0; i < 16 * 528; i++)
					if (mem.exists((row & ~15) * 528 + i))
						mem.delete((row & ~15) * 528 + i);
				hold_busy(ERASE_NS);
			end
			if (bus_in == 8'hff)
				hold_busy(100);
		end else if (!ce_n_in && ale_in) begin
			a[acnt] = bus_in;
			acnt++;
			if (acnt == 2 && cmd == 8'h60)
				row = {a[1][4:0], a[0]};
			if (acnt == 3) begin
				row = {a[2][4:0], a[1]};
				col = (cmd == 8'h50) ? 512 + a[0][3:0] : {half, a[0]};
				half = 1'b0;
				if (cmd != 8'h80)
					hold_busy(READ_NS);
			end
		end else if (!ce_n_in) begin
			pbuf[col] = bus_in;
			col++;
		end
	end

	// A falling read strobe puts out the next byte and moves the column on.
	always @(negedge read_strobe_n_in) begin
		if (!ce_n_in) begin
			#20;
			if (cmd == 8'h70)
				bus_out = {wp_n_in, ready_busy_n_out, 6'h00};
			else
				bus_out = mem.exists(row * 528 + col) ? mem[row * 528 + col] : 8'hff;
			col++;
		end
	end

	// Past the hold time the released bus shows a wrong value, never the last one.
	always @(posedge read_strobe_n_in) begin
		#30;
		bus_out = ~bus_out;
	end
endmodule : nand_card_model

/* dv/nand_host_ctrl_tb_top.sv */
// Self-checking bench: host controller against the behavioural card model.
`timescale 1ns/1ns
module nand_host_ctrl_tb_top import nand_host_pkg::*;;
	logic              core_clk_in, sys_rst_in, start_in, power_good_in, wr_valid_in;
	op_t               op_in;
	logic [ADDR_W-1:0] addr_in;
	logic [LEN_W-1:0]  len_in;
	logic [7:0]        wr_data_in, rd_data_out, port_out, dev_bus;
	logic              wr_ready_out, rd_valid_out, busy_out, done_out, timeout_out;
	logic              bad_block_out, port_oe_out, cle_out, ale_out, ce_n_out, we_n_out;
	logic              read_strobe_n_out, wp_n_out, ready_busy_n;
	wire  [7:0]        port_in = port_oe_out ? port_out : dev_bus;
	logic [7:0]        wq[$];
	logic [7:0]        rq[$];
	logic [12:0]       row = 13'h1a5a;
	int                miscompares, tests_run, cycles;
	bit                exp_to;

	nand_host_ctrl #(.BUSY_LIMIT_CYC(200)) uut (.core_clk_in, .sys_rst_in, .start_in, .op_in,
		.addr_in, .len_in, .power_good_in, .wr_valid_in, .wr_data_in, .wr_ready_out,
		.rd_valid_out, .rd_data_out, .busy_out, .done_out, .timeout_out, .bad_block_out,
		.port_in, .port_out, .port_oe_out, .cle_out, .ale_out, .ce_n_out, .we_n_out,
		.read_strobe_n_out, .wp_n_out, .ready_busy_n_in(ready_busy_n));
	nand_card_model card (.ce_n_in(ce_n_out), .cle_in(cle_out), .ale_in(ale_out),
		.we_n_in(we_n_out), .read_strobe_n_in(read_strobe_n_out), .wp_n_in(wp_n_out),
		.bus_in(port_out), .bus_out(dev_bus), .ready_busy_n_out(ready_busy_n));

	// ==========================================================================
	// Clock, and a cycle ceiling so that a hang still reaches the report.
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks run %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One user operation; write bytes come from wq, read bytes are gathered in rq.
	task automatic run_op(input op_t op, input logic [21:0] a, input logic [9:0] n);
		int t;
		int wi;
		bit fin;
		bit tk;
		bit bz;
		t = 0;
		wi = 0;
		fin = 1'b0;
		rq.delete();
		@(posedge core_clk_in);
		op_in <= op;
		addr_in <= a;
		len_in <= n;
		start_in <= 1'b1;
		wr_valid_in <= wq.size() > 0;
		wr_data_in <= wq.size() > 0 ? wq[0] : 8'h00;
		while (t < 3000) begin
			@(negedge core_clk_in);
			t++;
			if (rd_valid_out === 1'b1)
				rq.push_back(rd_data_out);
			fin = done_out === 1'b1;
			tk = wr_ready_out === 1'b1 && wr_valid_in === 1'b1;
			bz = busy_out === 1'b1;
			if (fin)
				break;
			@(posedge core_clk_in);
			if (bz)
				start_in <= 1'b0;
			if (tk) begin
				wi++;
				wr_valid_in <= wi < wq.size();
				wr_data_in <= wi < wq.size() ? wq[wi] : 8'h00;
			end
		end
		@(posedge core_clk_in);
		start_in <= 1'b0;
		wr_valid_in <= 1'b0;
		wq.delete();
		check({7'h00, fin}, 8'h01);
		check({7'h00, timeout_out}, {7'h00, exp_to});
	endtask : run_op

	task automatic t_prog_read();
		wq = '{8'h11, 8'h22, 8'h33, 8'h44};
		run_op(OP_PROGRAM, {row, 9'h0fe}, 10'd4);
		run_op(OP_READ, {row, 9'h0fe}, 10'd4);
		check(8'(rq.size()), 8'h04);
		foreach (rq[i]) check(rq[i], 8'(17 * (i + 1)));
		run_op(OP_READ, {row, 9'h100}, 10'd2);
		check(rq[0], 8'h33);
		check(rq[1], 8'h44);
		run_op(OP_READ, {row, 9'h0ff}, 10'd1);
		check(rq[0], 8'h22);
	endtask : t_prog_read

	task automatic t_erase();
		run_op(OP_ERASE, {row, 9'h000}, 10'd0);
		run_op(OP_READ, {row, 9'h0fe}, 10'd2);
		check(rq[0], 8'hff);
		check(rq[1], 8'hff);
	endtask : t_erase

	// With supply unsteady the program must not reach the array.
	task automatic t_lockout();
		@(posedge core_clk_in);
		power_good_in <= 1'b0;
		wq = '{8'h5a};
		run_op(OP_PROGRAM, {row, 9'h010}, 10'd1);
		check({7'h00, wp_n_out}, 8'h00);
		run_op(OP_READ, {row, 9'h010}, 10'd1);
		check(rq[0], 8'hff);
		@(posedge core_clk_in);
		power_good_in <= 1'b1;
	endtask : t_lockout

	task automatic t_badblk();
		logic [12:0] rows[3] = '{13'd48, 13'd80, 13'd96};
		logic        exp[3] = '{1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 3; i++) begin
			run_op(OP_BADCHK, {rows[i], 9'h000}, 10'd1);
			check({7'h00, bad_block_out}, {7'h00, exp[i]});
		end
	endtask : t_badblk

	// Status, reset, then an unknown operation code that must be ignored.
	task automatic t_misc();
		run_op(OP_STATUS, 22'h0, 10'd1);
		check(rq[0], 8'hc0);
		run_op(OP_RESET, 22'h0, 10'd0);
		@(posedge core_clk_in);
		op_in <= op_t'(3'b110);
		start_in <= 1'b1;
		repeat (6) begin
			@(negedge core_clk_in);
			check({7'h00, busy_out}, 8'h00);
		end
		@(posedge core_clk_in);
		start_in <= 1'b0;
	endtask : t_misc

	// A card stuck busy: the wait gives up with no data, and a start is refused until ready.
	task automatic t_stuck();
		card.stretch_ns = 30000;
		exp_to = 1'b1;
		run_op(OP_READ, {row, 9'h000}, 10'd1);
		check(8'(rq.size()), 8'h00);
		exp_to = 1'b0;
		@(posedge core_clk_in);
		start_in <= 1'b1;
		repeat (4) begin
			@(negedge core_clk_in);
			check({7'h00, busy_out}, 8'h00);
		end
		@(posedge core_clk_in);
		start_in <= 1'b0;
		card.stretch_ns = 0;
		wait (ready_busy_n === 1'b1);
	endtask : t_stuck

	// Main sequence: reset for two cycles, then each scenario in turn.
	initial begin
		sys_rst_in = 1'b1;
		start_in = 1'b0;
		power_good_in = 1'b1;
		wr_valid_in = 1'b0;
		wr_data_in = 8'h00;
		op_in = OP_STATUS;
		addr_in = '0;
		len_in = '0;
		repeat (2) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		t_misc();
		t_prog_read();
		t_erase();
		t_lockout();
		t_badblk();
		t_stuck();
		wrap_up();
	end
endmodule : nand_host_ctrl_tb_top
